/* asp_pkg.sv */
// constants shared by the asynchronous serial port files
package asp_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned BAUD_DEFAULT = 115200;
   localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
   localparam logic [15:0] DIV_ONE = 16'h0001;
   localparam logic [3:0] BITS_8 = 4'h9;
   localparam logic [3:0] BITS_9 = 4'ha;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [1:0] SYNC_IDLE = 2'h3;
   localparam logic [8:0] SHIFT_IDLE = 9'h1ff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   typedef enum logic [2:0]
   {
      ASP_IDLE = 3'b001,
      ASP_DATA = 3'b010,
      ASP_STOP = 3'b100
   } asp_state_type;
endpackage

/* asp_sync.sv */
// three-stage synchroniser for an asynchronous pin, with agreement filter
`timescale 1ns/1ns
module asp_sync
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic pin,
   output logic level
);
   import asp_pkg::*;
   logic s1;
   logic [1:0] s23;
   logic next_level;

   // a change counts only when stages two and three agree
   always_comb
   begin
      next_level = level;
      if (s23[0] == s23[1])
      begin
         next_level = s23[0];
      end
   end

   // stage one feeds only stage two
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s1 <= 1'b1;
         s23 <= SYNC_IDLE;
         level <= 1'b1;
      end
      else
      begin
         s1 <= pin;
         s23 <= {s23[0], s1};
         level <= next_level;
      end
   end
endmodule

/* asp_core.sv */
// full-duplex 8/9-bit asynchronous serial port
`timescale 1ns/1ns
module asp_core
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [15:0] bit_div,
   input wire logic frame_width_select,
   input wire logic receive_enable_bit,
   input wire logic multiproc_check_enable,
   input wire logic transmit_ninth_bit,
   input wire logic interrupt_enable,
   input wire logic buffer_write,
   input wire logic [7:0] buffer_write_data,
   input wire logic transmit_done_clear,
   input wire logic receive_done_clear,
   input wire logic receive_pin,
   output logic transmit_pin,
   output logic [7:0] serial_buffer_register,
   output logic received_ninth_bit,
   output logic transmit_done_flag,
   output logic receive_done_flag,
   output logic tx_busy,
   output logic irq
);
   import asp_pkg::*;

   logic rx_level;
   asp_state_type tx_state, next_tx_state, rx_state, next_rx_state;
   logic [15:0] tx_tick, next_tx_tick, rx_tick, next_rx_tick;
   logic [3:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
   logic [8:0] tx_shift, next_tx_shift, rx_shift, next_rx_shift;
   logic next_transmit_pin, next_transmit_done_flag, next_receive_done_flag;
   logic [7:0] next_serial_buffer_register;
   logic next_received_ninth_bit;
   logic tx_bit_end, rx_bit_end;
   logic [3:0] frame_bits;
   logic [15:0] div_eff;

   asp_sync u_rx_sync
   (
      .core_clk(core_clk),
      .srst(srst),
      .pin(receive_pin),
      .level(rx_level)
   );

   // zero divider would stretch each bit to 65536 cycles, so treat it as one
   assign div_eff = (bit_div == 16'h0000) ? DIV_ONE : bit_div;
   assign frame_bits = frame_width_select ? BITS_9 : BITS_8;
   assign tx_bit_end = (tx_tick == div_eff - DIV_ONE);
   assign rx_bit_end = (rx_tick == div_eff - DIV_ONE);
   assign tx_busy = (tx_state != ASP_IDLE);
   assign irq = interrupt_enable & (transmit_done_flag | receive_done_flag);

   // transmit path: start bit, data and optional ninth bit, then stop
   always_comb
   begin
      next_tx_state = tx_state;
      next_tx_tick = tx_tick;
      next_tx_cnt = tx_cnt;
      next_tx_shift = tx_shift;
      next_transmit_pin = transmit_pin;
      next_transmit_done_flag = transmit_done_flag;
      if (transmit_done_clear)
      begin
         next_transmit_done_flag = 1'b0;
      end
      case (tx_state)
         ASP_IDLE:
         begin
            next_transmit_pin = 1'b1;
            if (buffer_write)
            begin
               next_tx_shift = {transmit_ninth_bit, buffer_write_data};
               next_transmit_pin = 1'b0;
               next_tx_tick = 16'h0000;
               next_tx_cnt = CNT_ONE;
               next_tx_state = ASP_DATA;
            end
         end
         ASP_DATA:
         begin
            next_tx_tick = tx_tick + DIV_ONE;
            if (tx_bit_end)
            begin
               next_tx_tick = 16'h0000;
               if (tx_cnt == frame_bits)
               begin
                  next_transmit_pin = 1'b1;
                  next_transmit_done_flag = 1'b1;
                  next_tx_state = ASP_STOP;
               end
               else
               begin
                  next_transmit_pin = tx_shift[0];
                  next_tx_shift = {1'b1, tx_shift[8:1]};
                  next_tx_cnt = tx_cnt + CNT_ONE;
               end
            end
         end
         ASP_STOP:
         begin
            next_tx_tick = tx_tick + DIV_ONE;
            if (tx_bit_end)
            begin
               next_tx_state = ASP_IDLE;
            end
         end
         default:
         begin
            next_tx_state = ASP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         tx_state <= ASP_IDLE;
         tx_tick <= 16'h0000;
         tx_cnt <= CNT_ZERO;
         tx_shift <= SHIFT_IDLE;
         transmit_pin <= 1'b1;
         transmit_done_flag <= 1'b0;
      end
      else
      begin
         tx_state <= next_tx_state;
         tx_tick <= next_tx_tick;
         tx_cnt <= next_tx_cnt;
         tx_shift <= next_tx_shift;
         transmit_pin <= next_transmit_pin;
         transmit_done_flag <= next_transmit_done_flag;
      end
   end

   // receive path, separate pin and counters so it runs beside transmit
   always_comb
   begin
      next_rx_state = rx_state;
      next_rx_tick = rx_tick;
      next_rx_cnt = rx_cnt;
      next_rx_shift = rx_shift;
      next_serial_buffer_register = serial_buffer_register;
      next_received_ninth_bit = received_ninth_bit;
      next_receive_done_flag = receive_done_flag;
      if (receive_done_clear)
      begin
         next_receive_done_flag = 1'b0;
      end
      case (rx_state)
         ASP_IDLE:
         begin
            if (receive_enable_bit && !rx_level)
            begin
               next_rx_tick = 16'h0000;
               next_rx_cnt = CNT_ZERO;
               next_rx_state = ASP_DATA;
            end
         end
         ASP_DATA:
         begin
            next_rx_tick = rx_tick + DIV_ONE;
            // sample at mid-bit; a start bit gone high again is a glitch
            if (rx_tick == {1'b0, div_eff[15:1]})
            begin
               if (rx_cnt == CNT_ZERO && rx_level)
               begin
                  next_rx_state = ASP_IDLE;
               end
               else if (rx_cnt != CNT_ZERO)
               begin
                  next_rx_shift = {rx_level, rx_shift[8:1]};
               end
            end
            if (rx_bit_end)
            begin
               next_rx_tick = 16'h0000;
               next_rx_cnt = rx_cnt + CNT_ONE;
               if (rx_cnt == frame_bits - CNT_ONE)
               begin
                  next_rx_state = ASP_STOP;
               end
            end
         end
         ASP_STOP:
         begin
            next_rx_tick = rx_tick + DIV_ONE;
            if (rx_tick == {1'b0, div_eff[15:1]})
            begin
               next_rx_state = ASP_IDLE;
               // a full buffer keeps its first byte; this frame is lost
               if (!receive_done_flag)
               begin
                  if (frame_width_select)
                  begin
                     next_received_ninth_bit = rx_shift[8];
                     next_serial_buffer_register = rx_shift[7:0];
                     next_receive_done_flag = 1'b1;
                  end
                  else if (!multiproc_check_enable || rx_level)
                  begin
                     next_serial_buffer_register = rx_shift[8:1];
                     next_received_ninth_bit = rx_level;
                     next_receive_done_flag = 1'b1;
                  end
               end
            end
         end
         default:
         begin
            next_rx_state = ASP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         rx_state <= ASP_IDLE;
         rx_tick <= 16'h0000;
         rx_cnt <= CNT_ZERO;
         rx_shift <= SHIFT_IDLE;
         serial_buffer_register <= BYTE_ZERO;
         received_ninth_bit <= 1'b0;
         receive_done_flag <= 1'b0;
      end
      else
      begin
         rx_state <= next_rx_state;
         rx_tick <= next_rx_tick;
         rx_cnt <= next_rx_cnt;
         rx_shift <= next_rx_shift;
         serial_buffer_register <= next_serial_buffer_register;
         received_ninth_bit <= next_received_ninth_bit;
         receive_done_flag <= next_receive_done_flag;
      end
   end
endmodule

/* asp_core_props.sv */
// assertion checker for the serial port pins and flags
`timescale 1ns/1ns
module asp_core_props
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic receive_enable_bit,
   input wire logic interrupt_enable,
   input wire logic buffer_write,
   input wire logic transmit_done_clear,
   input wire logic receive_done_clear,
   input wire logic transmit_pin,
   input wire logic [7:0] serial_buffer_register,
   input wire logic transmit_done_flag,
   input wire logic receive_done_flag,
   input wire logic tx_busy,
   input wire logic irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // interrupt is the enabled or of both flags
   irq_follows_a:
      assert property (irq == (interrupt_enable & (transmit_done_flag | receive_done_flag)))
      else $error("irq does not follow flags");
   tx_start_a:
      assert property (buffer_write && !tx_busy |=> !transmit_pin && tx_busy)
      else $error("write did not start frame");
   idle_high_a:
      assert property (!tx_busy |-> transmit_pin) else $error("line not idle high");
   tx_at_stop_a:
      assert property ($rose(transmit_done_flag) |-> transmit_pin && tx_busy)
      else $error("tx flag not at stop start");
   tx_sticky_a:
      assert property (transmit_done_flag && !transmit_done_clear |=> transmit_done_flag)
      else $error("tx flag dropped");
   rx_sticky_a:
      assert property (receive_done_flag && !receive_done_clear |=> receive_done_flag)
      else $error("rx flag dropped");
   rx_keep_a:
      assert property (receive_done_flag |=> $stable(serial_buffer_register))
      else $error("buffer changed while full");
   rx_enable_a:
      assert property ($rose(receive_done_flag) |-> $past(receive_enable_bit))
      else $error("load while disabled");
   cover property ($rose(transmit_done_flag));
   cover property ($rose(receive_done_flag));
   cover property (buffer_write && tx_busy);
endmodule
bind asp_core asp_core_props u_props (.core_clk, .srst, .receive_enable_bit,
   .interrupt_enable, .buffer_write, .transmit_done_clear, .receive_done_clear,
   .transmit_pin, .serial_buffer_register, .transmit_done_flag, .receive_done_flag,
   .tx_busy, .irq);

/* asp_remote.sv */
// far-end serial transceiver model
`timescale 1ns/1ns
module asp_remote #(parameter int DIV = 8)
(
   input wire logic core_clk,
   input wire logic nine,
   input wire logic line_in,
   output logic line_out
);
   logic [8:0] got[$];
   logic [8:0] word;
   initial line_out = 1'b1;
   // start low, data lsb first, ninth in wide mode, then stop
   task automatic send(input logic [8:0] d, input logic stop_bit);
      int n;
      n = nine ? 9 : 8;
      @(posedge core_clk);
      line_out <= 1'b0;
      repeat (DIV) @(posedge core_clk);
      for (int i = 0; i < n; i++)
      begin
         line_out <= d[i];
         repeat (DIV) @(posedge core_clk);
      end
      line_out <= stop_bit;
      repeat (DIV) @(posedge core_clk);
      line_out <= 1'b1;
   endtask
   // mid-bit sampling; ninth sample is the stop bit in narrow mode
   always
   begin
      @(negedge line_in);
      repeat (DIV / 2) @(posedge core_clk);
      for (int i = 0; i < 9; i++)
      begin
         repeat (DIV) @(posedge core_clk);
         word[i] = line_in;
      end
      got.push_back(word);
   end
endmodule

/* asp_core_tb_top.sv */
// self-checking bench for the serial port
`timescale 1ns/1ns
module asp_core_tb_top;
   logic core_clk = 1'b0;
   logic srst, frame_width_select, receive_enable_bit, multiproc_check_enable;
   logic transmit_ninth_bit, interrupt_enable, buffer_write, transmit_done_clear;
   logic receive_done_clear, receive_pin, transmit_pin, received_ninth_bit;
   logic transmit_done_flag, receive_done_flag, tx_busy, irq;
   logic [7:0] buffer_write_data, serial_buffer_register;
   logic [8:0] d, r, e;
   // model of the words the far end should see, in send order
   logic [8:0] tx_model[$];
   int failures = 0;
   int tests_run = 0;
   always #5 core_clk = ~core_clk;
   asp_core u_asp_core (.core_clk, .srst, .bit_div(16'h0008), .frame_width_select,
      .receive_enable_bit, .multiproc_check_enable, .transmit_ninth_bit,
      .interrupt_enable, .buffer_write, .buffer_write_data, .transmit_done_clear,
      .receive_done_clear, .receive_pin, .transmit_pin, .serial_buffer_register,
      .received_ninth_bit, .transmit_done_flag, .receive_done_flag, .tx_busy, .irq);
   asp_remote u_asp_remote (.core_clk, .nine(frame_width_select),
      .line_in(transmit_pin), .line_out(receive_pin));
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // bounded wait for a done flag; a hang ends the run
   task automatic wait_flag(input bit rx);
      int n;
      n = 0;
      while ((rx ? receive_done_flag : transmit_done_flag) !== 1'b1)
      begin
         step(1);
         n++;
         if (n > 300)
         begin
            failures++;
            stop_test();
         end
      end
   endtask
   task automatic send_byte(input logic [8:0] v, input logic s);
      u_asp_remote.send(v, s);
      step(6);
   endtask
   initial
   begin
      {srst, frame_width_select, receive_enable_bit, multiproc_check_enable} = 4'b1010;
      {transmit_ninth_bit, interrupt_enable, buffer_write} = 3'b010;
      {transmit_done_clear, receive_done_clear} = 2'b00;
      buffer_write_data = 8'h00;
      void'($urandom(32'hcdb5b0e2));
      step(8);
      srst = 1'b0;
      // duplex frames in both widths; second write lands while busy
      for (int m = 0; m < 4; m++)
      begin
         frame_width_select = m[1];
         d = 9'($urandom);
         r = 9'($urandom);
         {transmit_ninth_bit, buffer_write_data} = d;
         // narrow frames carry a high stop bit where the ninth would sit
         tx_model.push_back(m[1] ? d : {1'b1, d[7:0]});
         buffer_write = 1'b1;
         fork
            u_asp_remote.send(r, 1'b1);
         join_none
         step(1);
         buffer_write_data = ~d[7:0];
         step(1);
         buffer_write = 1'b0;
         wait_flag(1'b0);
         wait_flag(1'b1);
         check({8'h00, irq}, 9'h001);
         step(8);
         check({8'h00, tx_busy}, 9'h000);
         e = tx_model.pop_front();
         check(u_asp_remote.got.pop_front(), e);
         e = m[1] ? r : {1'b1, r[7:0]};
         check({received_ninth_bit, serial_buffer_register}, e);
         {transmit_done_clear, receive_done_clear} = 2'b11;
         step(1);
         {transmit_done_clear, receive_done_clear} = 2'b00;
         $display("duplex test %0d done", m);
      end
      // overrun, failed stop check, disabled receiver, wide stop ignored
      frame_width_select = 1'b0;
      send_byte(9'h0a5, 1'b1);
      send_byte(9'h05a, 1'b1);
      check({receive_done_flag, serial_buffer_register}, 9'h1a5);
      interrupt_enable = 1'b0;
      receive_done_clear = 1'b1;
      step(1);
      receive_done_clear = 1'b0;
      check({8'h00, irq}, 9'h000);
      multiproc_check_enable = 1'b1;
      send_byte(9'h0c3, 1'b0);
      check({receive_done_flag, serial_buffer_register}, 9'h0a5);
      check({8'h00, received_ninth_bit}, 9'h001);
      {receive_enable_bit, multiproc_check_enable} = 2'b00;
      send_byte(9'h03c, 1'b1);
      check({receive_done_flag, serial_buffer_register}, 9'h0a5);
      {receive_enable_bit, multiproc_check_enable, frame_width_select} = 3'b111;
      send_byte(9'h13c, 1'b0);
      check({received_ninth_bit, serial_buffer_register}, 9'h13c);
      $display("receive corner test done");
      stop_test();
   end
endmodule
